// ### src/pmx_port0_mux.sv
// Functional notes
// - One select register per pin, consecutive indices
// - Eight bits, read/write, reset to zero
// - Bit 0 enables general I/O
// - Bit 1 feeds pin interrupt 0
// - Bit 2 feeds interrupt 1 on pins 0,3,4
// - Interrupts OR all selected pins, both allowed
// - Pin 0 bits: touch, i2c data, capture0, spi
// - Pin 1 bits: pulse0, i2c clocks, capture1, spi, data
// - Pin 2 bits: pulse1, serial rx, capture2, spi, clock
// - Pin 3 bits: pulse2, serial tx, capture3, spi select
// - Pin 4 bits: pulse10, i2c data, spi; bit 4 unused
`timescale 1ns/1ps
`include "pmx_regs.svh"
module pmx_port0_mux (
   // Clock and reset
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   // AHB-Lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic [31:0]               hrdata,
   output logic                      hresp,
   // Pad side
   input  wire logic [4:0]           pin_in,
   output logic [4:0]                pin_out,
   output logic [4:0]                pin_oe,
   // Peripheral side
   input  wire pmx_pkg::pmx_src_t [4:0] periph_src,
   output logic [4:0][7:0]           periph_in,
   output logic                      pin_irq0,
   output logic                      pin_irq1
);
   import pmx_pkg::*;

   // Function-capable bits of each pin; bit 2 is a function only on pins 1 and 2
   localparam logic [4:0][7:0] FUNC_MASK = {`PMX_FUNC_MASK_P04,
                                            `PMX_FUNC_MASK_P03,
                                            `PMX_FUNC_MASK_P02,
                                            `PMX_FUNC_MASK_P01,
                                            `PMX_FUNC_MASK_P00};
   localparam logic [4:0] IRQ1_PINS = `PMX_IRQ1_PIN_MASK;
   localparam logic [15:0] BASE_INDEX = `PMX_PIN00_INDEX;

   pmx_state_t st_r;
   pmx_state_t st_nxt;

   // Decode a byte address into a select-register slot
   function automatic logic [3:0] pmx_decode(input logic [31:0] a);
      logic [15:0] off;
      off = a[17:2] - BASE_INDEX;
      if (a[31:18] == 14'h0000 && a[1:0] == 2'b00 && off < 16'(`PMX_NUM_PINS)) begin
         pmx_decode = {1'b1, off[2:0]};
      end else begin
         pmx_decode = 4'h0;
      end
   endfunction

   // Pick the highest set bit; one priority order keeps the pad deterministic
   function automatic pmx_pick_t pmx_top_bit(input logic [7:0] v);
      pmx_pick_t p;
      p = '0;
      for (int i = 0; i < 8; i++) begin
         if (v[i]) begin
            p.hit = 1'b1;
            p.bit_idx = 3'(i);
         end
      end
      pmx_top_bit = p;
   endfunction

   logic       acc;
   logic [3:0] dec;
   logic [7:0] rd_val;
   pmx_pick_t  pick [4:0];

   // Address phase qualification and read forwarding
   always_comb begin
      acc = hsel && hready && htrans[1];
      dec = pmx_decode(haddr);
      rd_val = st_r.sel_r[dec[2:0]];
      // A write still in its data phase would otherwise read back stale
      if (st_r.wr_pend_r && st_r.wr_idx_r == dec[2:0]) begin
         rd_val = hwdata[7:0];
      end
   end

   // Next state: register file, bus answer and routing
   always_comb begin
      st_nxt = st_r;
      st_nxt.ready_r = 1'b1;
      st_nxt.wr_pend_r = 1'b0;
      // Data phase of an accepted write
      if (st_r.wr_pend_r) begin
         st_nxt.sel_r[st_r.wr_idx_r] = hwdata[7:0];
      end
      // Address phase; unmapped reads give zero, unmapped writes vanish
      if (acc) begin
         if (hwrite) begin
            st_nxt.wr_pend_r = dec[3];
            st_nxt.wr_idx_r = dec[2:0];
         end else begin
            st_nxt.hrdata_r = dec[3] ? {24'h000000, rd_val} : 32'h00000000;
         end
      end
      // Pad and peripheral routing, one registered stage so switches are glitch-free
      st_nxt.irq0_r = 1'b0;
      st_nxt.irq1_r = 1'b0;
      for (int p = 0; p < `PMX_NUM_PINS; p++) begin
         pick[p] = pmx_top_bit(st_r.sel_r[p] & FUNC_MASK[p]);
         if (pick[p].hit) begin
            st_nxt.pin_out_r[p] = periph_src[p].out[pick[p].bit_idx];
            st_nxt.pin_oe_r[p] = periph_src[p].oe[pick[p].bit_idx];
         end else begin
            st_nxt.pin_out_r[p] = 1'b0;
            st_nxt.pin_oe_r[p] = 1'b0;
         end
         // Inputs reach every selected function, not just the winner
         st_nxt.route_r[p] = {8{pin_in[p]}} & st_r.sel_r[p] & FUNC_MASK[p];
         if (st_r.sel_r[p][`PMX_IRQ0_SRC_BIT] && pin_in[p]) begin
            st_nxt.irq0_r = 1'b1;
         end
         if (IRQ1_PINS[p] && st_r.sel_r[p][`PMX_IRQ1_SRC_BIT] && pin_in[p]) begin
            st_nxt.irq1_r = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
         st_r.sel_r <= {`PMX_NUM_PINS{`PMX_SEL_RESET}};
         st_r.ready_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flip-flops; hresp is tied to zero
   assign hreadyout = st_r.ready_r;
   assign hrdata = st_r.hrdata_r;
   assign hresp = 1'b0;
   assign pin_out = st_r.pin_out_r;
   assign pin_oe = st_r.pin_oe_r;
   assign periph_in = st_r.route_r;
   assign pin_irq0 = st_r.irq0_r;
   assign pin_irq1 = st_r.irq1_r;

   // Checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   logic acc_wr0;
   logic acc_rd0;
   assign acc_wr0 = acc && hwrite && haddr == {14'h0000, BASE_INDEX, 2'b00};
   assign acc_rd0 = acc && !hwrite && haddr == {14'h0000, BASE_INDEX, 2'b00} && !st_r.wr_pend_r;

   a_write_lands: assert property (acc_wr0 |=> ##1 st_r.sel_r[0] == $past(hwdata[7:0]))
      else $error("write did not reach pin 0 select");
   a_read_back: assert property (acc_rd0 |=> hrdata == {24'h000000, $past(st_r.sel_r[0])})
      else $error("read of pin 0 select wrong");
   a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_gpio_route: assert property (st_r.sel_r[0][7:0] == 8'h01 |=> pin_out[0] == $past(periph_src[0].out[0]))
      else $error("general io not routed");
   a_irq0_source: assert property (st_r.sel_r[1][1] && pin_in[1] |=> pin_irq0)
      else $error("irq0 source missed");
   a_irq1_skip: assert property (pin_in == 5'h02 |=> !pin_irq1)
      else $error("pin 1 drove irq1");
   a_irq_both: assert property (st_r.sel_r[4][2:1] == 2'b11 && pin_in[4] |=> pin_irq0 && pin_irq1)
      else $error("pin 4 not on both interrupts");
   a_top_priority: assert property (st_r.sel_r[0][7] && st_r.sel_r[0][3] |=> pin_out[0] == $past(periph_src[0].out[7]))
      else $error("priority pick wrong");
   a_unused_bit: assert property (st_r.sel_r[4] == 8'h10 |=> !pin_oe[4] && periph_in[4] == 8'h00)
      else $error("unused bit 4 of pin 4 acted");
   a_i2c_alt: assert property (st_r.sel_r[1][7:2] == 6'h01 |=> pin_oe[1] == $past(periph_src[1].oe[2]))
      else $error("pin 1 bit 2 not routed");
   a_effect_time: assert property (acc_wr0 ##1 hwdata[7:0] == 8'h01 |=> ##1 pin_out[0] == $past(periph_src[0].out[0]))
      else $error("select change late");

   // Bus side: every access is answered at once, so masters never stall
   a_ready_high: assert property (
         hreadyout)
      else $error("bus ready dropped");

   // No error response exists; unmapped space reads zero instead
   a_resp_okay: assert property (
         !hresp)
      else $error("error response seen");

   // Unmapped reads answer zero so probing a gap never returns stale data
   a_unmapped_read: assert property (
         acc && !hwrite && !dec[3]
         |=> hrdata == 32'h00000000)
      else $error("unmapped read not zero");

   // Unmapped writes must not open a data phase
   a_unmapped_write: assert property (
         acc && hwrite && !dec[3]
         |=> !st_r.wr_pend_r)
      else $error("unmapped write accepted");

   // A mapped write remembers its slot for the data phase
   a_write_slot: assert property (
         acc && hwrite && dec[3]
         |=> st_r.wr_pend_r && st_r.wr_idx_r == $past(dec[2:0]))
      else $error("write slot lost");

   // A write to pin 4 lands in its own slot two edges on
   a_write_pin4: assert property (
         acc && hwrite && dec == 4'hC
         |=> ##1 st_r.sel_r[4] == $past(hwdata[7:0]))
      else $error("write did not reach pin 4 select");

   // Selects move only in the data phase of an accepted write
   a_sel_hold: assert property (
         !st_r.wr_pend_r
         |=> st_r.sel_r == $past(st_r.sel_r))
      else $error("select changed without a write");

   // Read data stands until the next read is taken
   a_read_hold: assert property (
         !(acc && !hwrite)
         |=> hrdata == $past(hrdata))
      else $error("read data moved");

   // Quiet pads give quiet interrupts one cycle later
   a_irq_quiet: assert property (
         pin_in == 5'h00
         |=> !pin_irq0 && !pin_irq1)
      else $error("interrupt without a high pad");

   // With no interrupt-0 select anywhere, interrupt 0 stays low
   a_irq0_off: assert property (
         {st_r.sel_r[4][1], st_r.sel_r[3][1], st_r.sel_r[2][1], st_r.sel_r[1][1], st_r.sel_r[0][1]} == 5'h00
         |=> !pin_irq0)
      else $error("interrupt 0 without a source");

   // Pins 1 and 2 can never raise interrupt 1, whatever their bit 2 holds
   a_irq1_off: assert property (
         (pin_in & IRQ1_PINS) == 5'h00
         |=> !pin_irq1)
      else $error("interrupt 1 from a pin without that select");

   // Pin 3 feeds interrupt 0 when its bit 1 is set
   a_irq0_pin3: assert property (
         st_r.sel_r[3][1] && pin_in[3]
         |=> pin_irq0)
      else $error("pin 3 missed interrupt 0");

   // Pins 0 and 3 feed interrupt 1 through bit 2
   a_irq1_pin0: assert property (
         st_r.sel_r[0][2] && pin_in[0]
         |=> pin_irq1)
      else $error("pin 0 missed interrupt 1");

   a_irq1_pin3: assert property (
         st_r.sel_r[3][2] && pin_in[3]
         |=> pin_irq1)
      else $error("pin 3 missed interrupt 1");

   // Pin 4 bit 4 is storage only; it must never route the pad inward
   a_pin4_spare: assert property (
         st_r.sel_r[4][4] && pin_in[4]
         |=> !periph_in[4][4])
      else $error("pin 4 bit 4 routed");

   // Per-pin pad checks; one copy for each pin keeps the pins symmetric
   for (genvar g = 0; g < `PMX_NUM_PINS; g++) begin : g_pad_chk
      // No function selected: the pad is released and held low
      a_idle_pad: assert property (
            (st_r.sel_r[g] & FUNC_MASK[g]) == 8'h00
            |=> !pin_oe[g] && !pin_out[g])
         else $error("idle pad driven");

      // General I/O alone hands the pad to the port logic
      a_gpio_oe: assert property (
            (st_r.sel_r[g] & FUNC_MASK[g]) == 8'h01
            |=> pin_oe[g] == $past(periph_src[g].oe[0]))
         else $error("general io enable not picked");

      a_gpio_out: assert property (
            (st_r.sel_r[g] & FUNC_MASK[g]) == 8'h01
            |=> pin_out[g] == $past(periph_src[g].out[0]))
         else $error("general io level not picked");

      // Bit 7 is a function on every pin and outranks all others
      a_top_out: assert property (
            st_r.sel_r[g][7]
            |=> pin_out[g] == $past(periph_src[g].out[7]))
         else $error("top function level lost");

      a_top_oe: assert property (
            st_r.sel_r[g][7]
            |=> pin_oe[g] == $past(periph_src[g].oe[7]))
         else $error("top function enable lost");

      // Interrupt selects are not functions and never reach a peripheral
      a_irq_bits_in: assert property (
            !periph_in[g][1]
            && (!IRQ1_PINS[g] || !periph_in[g][2]))
         else $error("interrupt select routed inward");

      // A low pad reaches no peripheral input
      a_input_quiet: assert property (
            !pin_in[g]
            |=> periph_in[g] == 8'h00)
         else $error("input routed from a low pad");

      // A high pad reaches the top function's input
      a_input_route: assert property (
            pin_in[g] && st_r.sel_r[g][7]
            |=> periph_in[g][7])
         else $error("input not routed to top function");

      // Bits that are not functions never reach a peripheral
      a_route_mask: assert property (
            (periph_in[g] & ~FUNC_MASK[g]) == 8'h00)
         else $error("non-function bit routed inward");
   end

   // Spare bit on pin 4 and a probe of the gap above the registers
   c_spare_bit: cover property (st_r.sel_r[4] == 8'h10);
   c_unmapped: cover property (acc && !dec[3]);

   c_reg_write: cover property (acc_wr0 ##1 1'b1 ##1 st_r.sel_r[0] != 8'h00);
   c_irq_both: cover property (pin_irq0 && pin_irq1);
   c_conflict: cover property (st_r.sel_r[1][7] && st_r.sel_r[1][3] ##1 pin_oe[1]);

endmodule // pmx_port0_mux

// ### src/pmx_regs.svh
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH

// Register indices; byte address is four times the index
`define PMX_PIN00_INDEX   16'hA050
`define PMX_PIN01_INDEX   16'hA051
`define PMX_PIN02_INDEX   16'hA052
`define PMX_PIN03_INDEX   16'hA053
`define PMX_PIN04_INDEX   16'hA054
`define PMX_NUM_PINS      5
`define PMX_SEL_RESET     8'h00

// Field positions; bits 0 and 1 on every pin, bit 2 as interrupt-1 select on pins 0,3,4 only
`define PMX_GENERAL_IO_BIT   0
`define PMX_IRQ0_SRC_BIT     1
`define PMX_IRQ1_SRC_BIT     2

// Bits that select a pin-driving or pin-reading function, per pin
`define PMX_FUNC_MASK_P00 8'hF9
`define PMX_FUNC_MASK_P01 8'hFD
`define PMX_FUNC_MASK_P02 8'hFD
`define PMX_FUNC_MASK_P03 8'hF9
`define PMX_FUNC_MASK_P04 8'hE9

// Pins that carry a pin-interrupt-1 source select
`define PMX_IRQ1_PIN_MASK 5'h19

`endif

// ### src/pmx_pkg.sv
package pmx_pkg;

   // Per-pin signals offered by the peripherals, indexed by select bit
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pmx_src_t;

   // Whole state of the mux block
   typedef struct packed {
      logic [4:0][7:0] sel_r;
      logic            wr_pend_r;
      logic [2:0]      wr_idx_r;
      logic            ready_r;
      logic [31:0]     hrdata_r;
      logic [4:0]      pin_out_r;
      logic [4:0]      pin_oe_r;
      logic [4:0][7:0] route_r;
      logic            irq0_r;
      logic            irq1_r;
   } pmx_state_t;

   // Result of the priority pick
   typedef struct packed {
      logic       hit;
      logic [2:0] bit_idx;
   } pmx_pick_t;

endpackage

// ### tb/pmx_far_side.sv
`timescale 1ns/1ps
// Peripherals and pads beside the mux; one pattern feeds every pin
module pmx_far_side (
   // Bench control
   input  wire logic [7:0]         pat,
   input  wire logic [4:0]         pad_lvl,
   // Mux side
   output pmx_pkg::pmx_src_t [4:0] periph_src,
   output logic [4:0]              pin_in
);
   import pmx_pkg::*;
   // Each peripheral drives its pattern bit, enable always on
   always_comb begin
      for (int p = 0; p < 5; p++) begin
         periph_src[p].out = pat;
         periph_src[p].oe  = 8'hFF;
      end
   end
   // Plain pad levels; buffer setup, open-drain for i2c lines too, is outside this block
   assign pin_in = pad_lvl;
endmodule // pmx_far_side

// ### tb/port0_low_pin_function_mux_bench.sv
`timescale 1ns/1ps
`include "pmx_regs.svh"
module port0_low_pin_function_mux_bench;
   import pmx_pkg::*;
   logic            hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0]     haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
   logic [1:0]      htrans = 2'h0;
   logic [2:0]      hsize = 3'h2;
   logic [7:0]      pat = 8'h00, v;
   logic [7:0]      masks [5];
   logic [4:0]      pad_lvl = 5'h00, pin_out, pin_oe, pin_in;
   logic            hready, hreadyout, hresp, pin_irq0, pin_irq1;
   pmx_src_t [4:0]  periph_src;
   logic [4:0][7:0] periph_in;
   logic [4:0]      pads [5] = '{5'h02, 5'h08, 5'h00, 5'h11, 5'h06};
   int              bad_count = 0, compares = 0, cycles = 0;

   // Clock and the single slave's ready loop
   always #5 hclk = ~hclk;
   assign hready = hreadyout;

   pmx_port0_mux DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .periph_src(periph_src),
      .periph_in(periph_in), .pin_irq0(pin_irq0), .pin_irq1(pin_irq1));
   pmx_far_side FAR (.pat(pat), .pad_lvl(pad_lvl), .periph_src(periph_src), .pin_in(pin_in));

   task check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task finish_test;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Byte address is four times the register index
   function logic [31:0] addr_of(input int p);
      return (32'(`PMX_PIN00_INDEX) + 32'(p)) << 2;
   endfunction

   // One single AHB transfer; waits on ready, takes data at the closing edge
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // A hang counts as a mismatch; the whole run is far below this
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         finish_test();
      end
   end

   initial begin
      masks = '{`PMX_FUNC_MASK_P00, `PMX_FUNC_MASK_P01, `PMX_FUNC_MASK_P02,
                `PMX_FUNC_MASK_P03, `PMX_FUNC_MASK_P04};
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check({pin_out, pin_oe, pin_irq0, pin_irq1}, 32'h0);
      // Reset values, then distinct values with junk in the upper bytes
      for (int p = 0; p < 6; p++) begin
         ahb(1'b0, addr_of(p), 32'h0);
         check(rd, 32'h0);
      end
      for (int p = 0; p < 6; p++) ahb(1'b1, addr_of(p), 32'hFFFF_FF00 | (8'hA5 ^ p));
      for (int p = 0; p < 6; p++) begin
         ahb(1'b0, addr_of(p), 32'h0);
         check(rd, (p < 5) ? 32'(8'hA5 ^ p) : 32'h0);
      end
      // Each bit against GPIO: function bits win, others leave GPIO driving
      pad_lvl <= 5'h1F;
      for (int p = 0; p < 5; p++) begin
         for (int k = 0; k < 8; k++) begin
            v = (8'h01 << k) | 8'h01;
            pat <= 8'h01 << k;
            ahb(1'b1, addr_of(p), 32'(v));
            repeat (2) @(posedge hclk);
            check(pin_out[p], masks[p][k]);
            check(pin_oe[p], 1'b1);
            check(periph_in[p], v & masks[p]);
         end
      end
      // Both interrupt selects on every pin; pins 1 and 2 use bit 2 otherwise
      for (int p = 0; p < 5; p++) ahb(1'b1, addr_of(p), 32'h06);
      for (int i = 0; i < 5; i++) begin
         pad_lvl <= pads[i];
         repeat (3) @(posedge hclk);
         check({pin_irq0, pin_irq1}, {|pads[i], |(pads[i] & 5'h19)});
      end
      ahb(1'b1, addr_of(3), 32'h04);
      pad_lvl <= 5'h08;
      repeat (3) @(posedge hclk);
      check({pin_irq0, pin_irq1}, 2'b01);
      // Conflicts resolve upward; pin 4 bit 4 stores but routes nothing
      ahb(1'b1, addr_of(0), 32'h88);
      ahb(1'b1, addr_of(1), 32'h88);
      ahb(1'b1, addr_of(4), 32'h10);
      ahb(1'b0, addr_of(4), 32'h0);
      check(rd, 32'h10);
      repeat (2) @(posedge hclk);
      check(pin_oe, 5'h07);
      check(pin_out, 5'h03);
      check(periph_in[4], 8'h00);
      check({hreadyout, hresp}, 2'b10);
      // Second reset in mid-run clears the selects
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, addr_of(3), 32'h0);
      check(rd, 32'h0);
      finish_test();
   end
endmodule // port0_low_pin_function_mux_bench
